// >>> logic/ioc_consts.svh
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// ==========================================
// Register offsets (byte addresses)
`define OFF_PA_RISE 8'h00
`define OFF_PA_FALL 8'h04
`define OFF_PA_FLAG 8'h08
`define OFF_PB_RISE 8'h0c
`define OFF_PB_FALL 8'h10
`define OFF_PB_FLAG 8'h14
`define OFF_IRQ_CTRL 8'h18
`define OFF_IRQ_STAT 8'h1c
`define OFF_IRQ_MASK 8'h20

// ==========================================
// Field positions
`define PA_MSB 5
`define PB_MSB 7
`define PB_LSB 4
`define IRQEN_BIT 3
`define SUMMARY_BIT 0
`define EV_PA 0
`define EV_PB 1
`define EV_WAKE 2
`define EV_W 3

// ==========================================
// Reset values and timing
`define RST_BYTE 8'h00
`define RST_EV 3'h0
`define SYNC_PRIME 3'h5

`endif

// >>> logic/ioc_pkg.sv
package ioc_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage

// >>> logic/pin_edge_sync.sv
module pin_edge_sync #(
	parameter int W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	import ioc_pkg::*;
	`include "ioc_consts.svh"

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] stable;
		logic [W-1:0] prev;
		logic [2:0] prime;
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;
	logic primed;

	// ==========================================
	// Synchroniser: a level counts once stages two and three agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.stable = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.stable);
		st_nxt.prev = st_r.stable;
		if (st_r.prime != `SYNC_PRIME) begin
			st_nxt.prime = st_r.prime + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Pins already high at reset release must not look like edges
	assign primed = (st_r.prime == `SYNC_PRIME);
	assign rise = primed ? (st_r.stable & ~st_r.prev) : '0;
	assign fall = primed ? (~st_r.stable & st_r.prev) : '0;
endmodule

// >>> logic/change_flag_bank.sv
module change_flag_bank #(
	parameter int W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] set,
	input wire logic wr_en,
	input wire logic [W-1:0] wr_data,
	output logic [W-1:0] flags
);
	import ioc_pkg::*;

	typedef struct packed {
		logic [W-1:0] flags;
	} bank_t;

	bank_t st_r;
	bank_t st_nxt;

	// ==========================================
	// Hardware set is OR-ed after the write so a racing edge is kept
	always_comb begin
		st_nxt = st_r;
		if (wr_en) begin
			st_nxt.flags = wr_data;
		end
		st_nxt.flags = st_nxt.flags | set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flags = st_r.flags;
endmodule

// >>> logic/port_change_irq.sv
module port_change_irq (
	input wire logic pclk,
	input wire logic presetn,
	input wire ioc_pkg::apb_req_t apb_req,
	output ioc_pkg::apb_rsp_t apb_rsp,
	input wire logic [5:0] porta_pin,
	input wire logic [7:4] portb_pin,
	input wire logic sleep,
	output logic change_irq,
	output logic change_irq_summary,
	output logic wake,
	output logic irq
);
	import ioc_pkg::*;
	`include "ioc_consts.svh"

	localparam int PA_W = `PA_MSB + 1;
	localparam int PB_W = `PB_MSB - `PB_LSB + 1;

	typedef struct packed {
		logic [PA_W-1:0] pa_rise;
		logic [PA_W-1:0] pa_fall;
		logic [PB_W-1:0] pb_rise;
		logic [PB_W-1:0] pb_fall;
		logic irq_en;
		logic [`EV_W-1:0] status;
		logic [`EV_W-1:0] mask;
		logic wake_d;
		logic [31:0] prdata;
		logic slverr;
	} regs_t;

	regs_t st_r;
	regs_t st_nxt;

	logic [PA_W-1:0] pa_rise_ev;
	logic [PA_W-1:0] pa_fall_ev;
	logic [PB_W-1:0] pb_rise_ev;
	logic [PB_W-1:0] pb_fall_ev;
	logic [PA_W-1:0] pa_set;
	logic [PB_W-1:0] pb_set;
	logic [PA_W-1:0] pa_flags;
	logic [PB_W-1:0] pb_flags;
	logic wr_acc;
	logic setup_rd;
	logic pa_flag_wr;
	logic pb_flag_wr;
	logic [`EV_W-1:0] ev;
	logic summary;
	logic wake_now;

	// ==========================================
	// Pin synchronisers and edge detectors
	pin_edge_sync #(.W(PA_W)) u_pa_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(porta_pin),
		.rise(pa_rise_ev),
		.fall(pa_fall_ev)
	);

	pin_edge_sync #(.W(PB_W)) u_pb_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(portb_pin),
		.rise(pb_rise_ev),
		.fall(pb_fall_ev)
	);

	// ==========================================
	// Per-pin flag set terms
	genvar gi;
	generate
		for (gi = 0; gi < PA_W; gi++) begin : g_pa
			assign pa_set[gi] = (st_r.pa_rise[gi] & pa_rise_ev[gi]) | (st_r.pa_fall[gi] & pa_fall_ev[gi]);
		end
		for (gi = 0; gi < PB_W; gi++) begin : g_pb
			assign pb_set[gi] = (st_r.pb_rise[gi] & pb_rise_ev[gi])
				| (st_r.pb_fall[gi] & pb_fall_ev[gi]);
		end
	endgenerate

	// ==========================================
	// APB decode: writes land at the access edge
	assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign setup_rd = apb_req.psel & ~apb_req.penable;
	assign pa_flag_wr = wr_acc & (apb_req.paddr == `OFF_PA_FLAG);
	assign pb_flag_wr = wr_acc & (apb_req.paddr == `OFF_PB_FLAG);

	// ==========================================
	// Change flag storage, set wins over a software write
	change_flag_bank #(.W(PA_W)) u_pa_flags (
		.pclk(pclk),
		.presetn(presetn),
		.set(pa_set),
		.wr_en(pa_flag_wr),
		.wr_data(apb_req.pwdata[`PA_MSB:0]),
		.flags(pa_flags)
	);

	change_flag_bank #(.W(PB_W)) u_pb_flags (
		.pclk(pclk),
		.presetn(presetn),
		.set(pb_set),
		.wr_en(pb_flag_wr),
		.wr_data(apb_req.pwdata[`PB_MSB:`PB_LSB]),
		.flags(pb_flags)
	);

	// ==========================================
	// Summary, wake and event sources
	assign summary = (|pa_flags) | (|pb_flags);
	// Flags are registers, so they are settled before wake reaches the core
	assign wake_now = sleep & st_r.irq_en & summary;
	assign ev[`EV_PA] = |pa_set;
	assign ev[`EV_PB] = |pb_set;
	assign ev[`EV_WAKE] = wake_now & ~st_r.wake_d;

	// ==========================================
	// Register file and read path
	always_comb begin
		st_nxt = st_r;
		st_nxt.wake_d = wake_now;
		if (wr_acc) begin
			unique case (apb_req.paddr)
				`OFF_PA_RISE: st_nxt.pa_rise = apb_req.pwdata[`PA_MSB:0];
				`OFF_PA_FALL: st_nxt.pa_fall = apb_req.pwdata[`PA_MSB:0];
				`OFF_PB_RISE: st_nxt.pb_rise = apb_req.pwdata[`PB_MSB:`PB_LSB];
				`OFF_PB_FALL: st_nxt.pb_fall = apb_req.pwdata[`PB_MSB:`PB_LSB];
				`OFF_IRQ_CTRL: st_nxt.irq_en = apb_req.pwdata[`IRQEN_BIT];
				`OFF_IRQ_STAT: st_nxt.status = st_r.status & ~apb_req.pwdata[`EV_W-1:0];
				`OFF_IRQ_MASK: st_nxt.mask = apb_req.pwdata[`EV_W-1:0];
				default: st_nxt.status = st_r.status;
			endcase
		end
		// A new event beats a write-one clear in the same cycle
		st_nxt.status = st_nxt.status | ev;
		if (setup_rd) begin
			st_nxt.prdata = '0;
			st_nxt.slverr = 1'b0;
			unique case (apb_req.paddr)
				`OFF_PA_RISE: st_nxt.prdata[`PA_MSB:0] = st_r.pa_rise;
				`OFF_PA_FALL: st_nxt.prdata[`PA_MSB:0] = st_r.pa_fall;
				`OFF_PA_FLAG: st_nxt.prdata[`PA_MSB:0] = pa_flags;
				`OFF_PB_RISE: st_nxt.prdata[`PB_MSB:`PB_LSB] = st_r.pb_rise;
				`OFF_PB_FALL: st_nxt.prdata[`PB_MSB:`PB_LSB] = st_r.pb_fall;
				`OFF_PB_FLAG: st_nxt.prdata[`PB_MSB:`PB_LSB] = pb_flags;
				`OFF_IRQ_CTRL: begin
					st_nxt.prdata[`IRQEN_BIT] = st_r.irq_en;
					st_nxt.prdata[`SUMMARY_BIT] = summary;
				end
				`OFF_IRQ_STAT: st_nxt.prdata[`EV_W-1:0] = st_r.status;
				`OFF_IRQ_MASK: st_nxt.prdata[`EV_W-1:0] = st_r.mask;
				default: st_nxt.slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// Outputs: zero wait states, answer prepared during setup
	assign apb_rsp.prdata = st_r.prdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = st_r.slverr & apb_req.psel & apb_req.penable;
	assign change_irq_summary = summary;
	assign change_irq = summary & st_r.irq_en;
	assign wake = wake_now;
	assign irq = |(st_r.status & st_r.mask);

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rise_sets_flag: assert property (
		(st_r.pb_rise[0] && pb_rise_ev[0]) |=> pb_flags[0]
	) else $error("rise-enabled edge did not set port b flag");

	a_fall_sets_flag: assert property (
		(st_r.pb_fall[1] && pb_fall_ev[1]) |=> pb_flags[1]
	) else $error("fall-enabled edge did not set port b flag");

	a_fall_disabled: assert property (
		(!st_r.pb_fall[0] && pb_fall_ev[0] && !pb_rise_ev[0] && !pb_flag_wr && !pb_flags[0])
		|=> !pb_flags[0]
	) else $error("disabled falling edge set a flag");

	a_flag_write_zero: assert property (
		(pb_flag_wr && !apb_req.pwdata[`PB_LSB] && !pb_set[0]) |=> !pb_flags[0]
	) else $error("writing zero did not clear flag");

	a_set_wins: assert property (
		(pb_flag_wr && pb_set[0]) |=> pb_flags[0]
	) else $error("edge lost during flag write");

	a_unimpl_zero: assert property (
		(setup_rd && (apb_req.paddr == `OFF_PB_FALL || apb_req.paddr == `OFF_PB_FLAG))
		|=> (apb_rsp.prdata[`PB_LSB-1:0] == 4'h0)
	) else $error("unimplemented port b bits read nonzero");

	a_summary_gate: assert property (
		change_irq == (st_r.irq_en && ((|pa_flags) || (|pb_flags)))
	) else $error("change interrupt not gated by enable");

	a_wake_follows: assert property (
		(sleep && st_r.irq_en && $rose(summary)) |-> wake
	) else $error("enabled change did not wake");

	a_edge_one_cycle: assert property (
		pb_rise_ev[0] |=> !pb_rise_ev[0]
	) else $error("edge pulse longer than one cycle");

	a_pa_flag_path: assert property (
		(st_r.pa_rise[0] && pa_rise_ev[0]) |=> change_irq_summary
	) else $error("port a edge did not reach summary");

	// ==========================================
	// Per-pin checks, port B
	for (gi = 0; gi < PB_W; gi++) begin : g_pb_chk
		a_pb_rise_bit: assert property (
			(st_r.pb_rise[gi] && pb_rise_ev[gi])
			|=> pb_flags[gi]
		) else $error("port b rising edge lost");

		a_pb_fall_bit: assert property (
			(st_r.pb_fall[gi] && pb_fall_ev[gi])
			|=> pb_flags[gi]
		) else $error("port b falling edge lost");

		a_pb_fall_off: assert property (
			(!st_r.pb_fall[gi] && !st_r.pb_rise[gi] && !pb_flag_wr && !pb_flags[gi])
			|=> !pb_flags[gi]
		) else $error("port b flag set with edges disabled");

		a_pb_flag_hold: assert property (
			(!pb_set[gi] && !pb_flag_wr)
			|=> (pb_flags[gi] == $past(pb_flags[gi]))
		) else $error("port b flag changed on its own");

		a_pb_clear_bit: assert property (
			(pb_flag_wr && !apb_req.pwdata[`PB_LSB + gi] && !pb_set[gi])
			|=> !pb_flags[gi]
		) else $error("port b flag not cleared by zero");

		a_pb_win_bit: assert property (
			(pb_flag_wr && pb_set[gi])
			|=> pb_flags[gi]
		) else $error("port b edge lost during write");

		a_pb_flag_read: assert property (
			(setup_rd && apb_req.paddr == `OFF_PB_FLAG)
			|=> (apb_rsp.prdata[`PB_LSB + gi] == $past(pb_flags[gi]))
		) else $error("port b flag read mismatch");

		a_pb_fall_read: assert property (
			(setup_rd && apb_req.paddr == `OFF_PB_FALL)
			|=> (apb_rsp.prdata[`PB_LSB + gi] == $past(st_r.pb_fall[gi]))
		) else $error("port b fall enable read mismatch");

		a_pb_one_dir: assert property (
			pb_rise_ev[gi]
			|-> !pb_fall_ev[gi]
		) else $error("port b rise and fall together");

		a_pb_fall_pulse: assert property (
			pb_fall_ev[gi]
			|=> !pb_fall_ev[gi]
		) else $error("port b fall pulse too long");
	end

	// ==========================================
	// Per-pin checks, port A
	for (gi = 0; gi < PA_W; gi++) begin : g_pa_chk
		a_pa_rise_bit: assert property (
			(st_r.pa_rise[gi] && pa_rise_ev[gi])
			|=> pa_flags[gi]
		) else $error("port a rising edge lost");

		a_pa_fall_bit: assert property (
			(st_r.pa_fall[gi] && pa_fall_ev[gi])
			|=> pa_flags[gi]
		) else $error("port a falling edge lost");

		a_pa_flag_sum: assert property (
			pa_flags[gi]
			|-> change_irq_summary
		) else $error("port a flag missing from summary");

		a_pa_rise_pulse: assert property (
			pa_rise_ev[gi]
			|=> !pa_rise_ev[gi]
		) else $error("port a rise pulse too long");
	end

	// ==========================================
	// Summary, status, wake and port B read checks
	a_irq_off_gate: assert property (
		!st_r.irq_en
		|-> !change_irq
	) else $error("change interrupt raised while disabled");

	a_summary_clear: assert property (
		(pa_flags == '0 && pb_flags == '0)
		|-> !change_irq_summary
	) else $error("summary set with no flag");

	a_chg_irq_event: assert property (
		(st_r.irq_en && (|pb_set) && !wr_acc)
		|=> change_irq
	) else $error("enabled port b edge raised no interrupt");

	a_status_event: assert property (
		(ev != '0)
		|=> ((st_r.status & $past(ev)) == $past(ev))
	) else $error("event did not reach status");

	a_wake_on_edge: assert property (
		(sleep && st_r.irq_en && ((|pa_set) || (|pb_set)) && !wr_acc) ##1 sleep
		|-> wake
	) else $error("edge in sleep did not wake");

	a_wake_needs_en: assert property (
		wake
		|-> (sleep && st_r.irq_en)
	) else $error("wake without sleep and enable");

	a_wake_flags_set: assert property (
		wake
		|-> change_irq_summary
	) else $error("wake before flags updated");

	a_pb_upper_zero: assert property (
		(setup_rd && (apb_req.paddr == `OFF_PB_FALL || apb_req.paddr == `OFF_PB_FLAG))
		|=> ((apb_rsp.prdata >> (`PB_MSB + 1)) == '0)
	) else $error("port b register read bits above field");
endmodule

// >>> tb/port_change_irq_tb_top.sv
`include "ioc_consts.svh"

module port_change_irq_tb_top;
	import ioc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic slp = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic [5:0] pa = 6'h00;
	logic [7:4] pb = 4'h0;
	logic cirq;
	logic summ;
	logic wk;
	logic irq;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [31:0] seed = 32'he70aefe6;
	logic [31:0] r;
	logic [7:0] a;
	int i;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	port_change_irq uut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(req),
		.apb_rsp(rsp),
		.porta_pin(pa),
		.portb_pin(pb),
		.sleep(slp),
		.change_irq(cirq),
		.change_irq_summary(summ),
		.wake(wk),
		.irq(irq)
	);

	initial begin
		forever #4 pclk = ~pclk;
	end

	// ==========================================
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(string n, logic [31:0] s, logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Expected answer is queued before the request so the monitor never pops empty
	task apb(logic w, logic [7:0] ad, logic [31:0] d, logic [32:0] x);
		q.push_back(x);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task wr(logic [7:0] ad, logic [31:0] d, logic err = 1'b0);
		apb(1'b1, ad, d, {err, 32'h0});
	endtask

	task rd(logic [7:0] ad, logic [31:0] x, logic err = 1'b0);
		apb(1'b0, ad, 32'h0, {err, x});
	endtask

	// Long enough for the synchroniser and flag stages to settle
	task st;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
	endtask

	// ==========================================
	// Monitor and timeout
	always @(posedge pclk) begin
		if (presetn && req.psel && req.penable && rsp.pready) begin
			e = q.pop_front();
			check("pslverr", 32'(rsp.pslverr), 32'(e[32]));
			if (!req.pwrite)
				check("prdata", rsp.prdata, e[31:0]);
		end
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			test_done();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		st;
		for (i = 0; i <= 32; i += 4)
			rd(8'(i), 32'h0);
		$display("test reset done");
		for (i = 0; i < 12; i++) begin
			r = xs();
			a = 8'(4 * (i % 6));
			wr(a, r);
			rd(a, r & (((i % 6) < 3) ? 32'h3f : 32'hf0));
		end
		wr(`OFF_PA_FLAG, 32'h0);
		wr(`OFF_PB_FLAG, 32'h0);
		wr(`OFF_IRQ_STAT, 32'h7);
		wr(`OFF_PB_RISE, 32'h0);
		wr(`OFF_PB_FALL, 32'hf0);
		$display("test fields done");
		@(posedge pclk);
		pb <= 4'hf;
		st;
		rd(`OFF_PB_FLAG, 32'h0);
		@(posedge pclk);
		pb <= 4'hd;
		st;
		rd(`OFF_PB_FLAG, 32'h20);
		wr(`OFF_PB_FALL, 32'h0);
		@(posedge pclk);
		pb <= 4'h0;
		st;
		rd(`OFF_PB_FLAG, 32'h20);
		wr(`OFF_PB_RISE, 32'h80);
		@(posedge pclk);
		pb <= 4'h8;
		st;
		rd(`OFF_PB_FLAG, 32'ha0);
		check("summary", 32'(summ), 32'h1);
		check("change_irq", 32'(cirq), 32'h0);
		$display("test edges done");
		rd(`OFF_IRQ_STAT, 32'h2);
		check("irq", 32'(irq), 32'h0);
		wr(`OFF_IRQ_MASK, 32'h2);
		st;
		check("irq", 32'(irq), 32'h1);
		wr(`OFF_IRQ_STAT, 32'h2);
		st;
		check("irq", 32'(irq), 32'h0);
		wr(`OFF_IRQ_CTRL, 32'h8);
		st;
		check("change_irq", 32'(cirq), 32'h1);
		rd(`OFF_IRQ_CTRL, 32'h9);
		@(posedge pclk);
		slp <= 1'b1;
		st;
		check("wake", 32'(wk), 32'h1);
		rd(`OFF_IRQ_STAT, 32'h4);
		wr(`OFF_IRQ_STAT, 32'h4);
		@(posedge pclk);
		slp <= 1'b0;
		wr(`OFF_IRQ_MASK, 32'h0);
		$display("test irq done");
		wr(`OFF_PB_FLAG, 32'ha0 & ~32'ha0);
		st;
		check("summary", 32'(summ), 32'h0);
		wr(`OFF_PB_RISE, 32'h10);
		wr(`OFF_PB_FALL, 32'h10);
		// The last pass lines the clearing write up with the hardware set
		for (i = 0; i < 3; i++) begin
			@(posedge pclk);
			pb[4] <= ~pb[4];
			repeat (i) @(posedge pclk);
			wr(`OFF_PB_FLAG, 32'h0);
			st;
			rd(`OFF_PB_FLAG, 32'h10);
			wr(`OFF_PB_FLAG, 32'h0);
		end
		$display("test clear done");
		wr(`OFF_PA_RISE, 32'h3f);
		@(posedge pclk);
		pa <= 6'h04;
		slp <= 1'b1;
		st;
		check("wake", 32'(wk), 32'h1);
		rd(`OFF_PA_FLAG, 32'h4);
		check("summary", 32'(summ), 32'h1);
		rd(`OFF_IRQ_STAT, 32'h7);
		rd(8'h24, 32'h0, 1'b1);
		wr(8'h24, 32'hff, 1'b1);
		rd(8'h24, 32'h0, 1'b1);
		$display("test porta done");
		st;
		test_done();
	end
endmodule
